// ==== logic/telegram_pkg.sv ====
// Package for the pushbutton telegram framer: frame constants, carriers, states.
// Assumes a single 100 MHz clock domain.
package telegram_pkg;

  localparam logic [7:0]  PREAMBLE_BYTE   = 8'h00;
  localparam int          PREAMBLE_LEN    = 4;
  localparam logic [7:0]  SFD_BYTE        = 8'ha7;
  localparam logic [7:0]  LEN_DATA        = 8'h18;
  localparam logic [7:0]  LEN_COMMISSION  = 8'h2a;
  localparam logic [15:0] FRAME_CTRL      = 16'h0801;
  localparam logic [15:0] DEST_PAN        = 16'hffff;
  localparam logic [15:0] DEST_ADDR       = 16'hffff;
  localparam logic [15:0] TELEGRAM_CTRL   = 16'h308c;
  localparam logic [15:0] CRC_POLY        = 16'h1021;
  localparam logic [15:0] CRC_INIT        = 16'h0000;
  localparam logic [7:0]  SEQ_RESET       = 8'h00;
  localparam logic [31:0] CNT_RESET       = 32'h0000_0000;
  localparam logic [4:0]  CHAN_MIN        = 5'd11;
  localparam logic [4:0]  CHAN_MAX        = 5'd26;
  localparam logic [4:0]  CHAN_DEFAULT    = 5'd11;
  localparam logic [11:0] FREQ_BASE_MHZ   = 12'd2405;
  localparam logic [11:0] FREQ_STEP_MHZ   = 12'd5;
  // Byte index of the length byte, of the last payload byte and of the last CRC byte (from byte 0 = preamble)
  localparam logic [5:0]  IDX_LEN         = 6'd5;
  localparam logic [5:0]  IDX_PAY_LAST    = 6'd27;
  localparam logic [5:0]  IDX_LAST        = 6'd29;

  // Contacts: two channels (A, B) of two contacts (0, 1)
  typedef struct packed {
    logic a0;
    logic a1;
    logic b0;
    logic b1;
  } contacts_t;

  // One button event to frame
  typedef struct packed {
    logic        release_evt;
    contacts_t   contacts;
    logic [7:0]  command;
    logic [31:0] signature;
  } event_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_DONE = 3'b100
  } state_t;

endpackage

// ==== logic/telegram_framer.sv ====
// Pushbutton telegram framer: builds one data telegram per bow event, byte stream out.
// Assumes the radio takes bytes on valid/ready and that the signature is supplied.
`timescale 1ns/1ns

// Behaviour
// - A press event and a release event each start their own telegram, told apart by the command.
// - Each telegram carries the 32-bit id; the four contacts (two channels of two) are captured but not sent.
// - Every multibyte field goes out least significant byte first.
// - The frame is PHY header, MAC header, MAC payload, then the CRC trailer, in that order.
// - The telegram begins with four zero preamble bytes.
// - The start delimiter 0xa7 follows the preamble.
// - The length byte follows, 0x18 for a data telegram (0x2a would be commissioning).
// - The frame control field is always 0x0801.
// - A one-byte sequence number follows and increments for each telegram sent.
// - The address is a destination network id and destination address, all ones.
// - No source address or source network id is sent.
// - Channels 11 to 26 are accepted while idle, channel 11 after reset.
// - Centre frequency is 2405 MHz plus 5 MHz per channel above 11.
// - The two-byte trailer is a CRC16 (x^16+x^12+x^5+1) over the length byte through the last payload byte.
// - Payload is telegram control 0x308c, source id, sequence counter, command, signature.
module telegram_framer
  import telegram_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID = 32'h1234_5678 // Arbitrary neutral identifier
)
(
  input  wire logic        core_clk_i,      // 100 MHz clock
  input  wire logic        rst_i,           // Synchronous reset, active high
  input  wire logic        evt_valid_i,     // Bow event request
  input  wire event_t      evt_i,           // Event: press/release, contacts, command, signature
  output logic             evt_ready_o,     // Framer idle, event taken
  input  wire logic        chan_wr_i,       // Channel select strobe
  input  wire logic [4:0]  chan_i,          // Requested channel number
  output logic [4:0]       chan_o,          // Active channel
  output logic [11:0]      freq_mhz_o,      // Active centre frequency in MHz
  output logic [7:0]       tx_data_o,       // Frame byte
  output logic             tx_valid_o,      // Frame byte valid
  input  wire logic        tx_ready_i,      // Radio accepts byte
  output logic             tx_last_o,       // Marks last CRC byte
  output logic             frame_done_o,    // One-cycle pulse after last byte taken
  output event_t           sent_evt_o       // Event of the telegram in flight
);

  state_t      state;
  logic [5:0]  idx;
  logic [7:0]  seq_num;
  logic [31:0] seq_cnt;
  logic [15:0] crc;
  event_t      cur;
  logic [7:0]  next_byte;
  logic [15:0] next_crc;
  logic        take;
  logic        fire;

  assign take = (state == ST_IDLE) && evt_valid_i;
  assign fire = tx_valid_o && tx_ready_i;

  // Byte at position idx of the data telegram
  always_comb
  begin
    case (idx)
      6'd0, 6'd1, 6'd2, 6'd3: next_byte = PREAMBLE_BYTE;
      6'd4:  next_byte = SFD_BYTE;
      6'd5:  next_byte = LEN_DATA;
      6'd6:  next_byte = FRAME_CTRL[7:0];
      6'd7:  next_byte = FRAME_CTRL[15:8];
      6'd8:  next_byte = seq_num;
      6'd9:  next_byte = DEST_PAN[7:0];
      6'd10: next_byte = DEST_PAN[15:8];
      6'd11: next_byte = DEST_ADDR[7:0];
      6'd12: next_byte = DEST_ADDR[15:8];
      6'd13: next_byte = TELEGRAM_CTRL[7:0];
      6'd14: next_byte = TELEGRAM_CTRL[15:8];
      6'd15: next_byte = DEVICE_ID[7:0];
      6'd16: next_byte = DEVICE_ID[15:8];
      6'd17: next_byte = DEVICE_ID[23:16];
      6'd18: next_byte = DEVICE_ID[31:24];
      6'd19: next_byte = seq_cnt[7:0];
      6'd20: next_byte = seq_cnt[15:8];
      6'd21: next_byte = seq_cnt[23:16];
      6'd22: next_byte = seq_cnt[31:24];
      6'd23: next_byte = cur.command;
      6'd24: next_byte = cur.signature[7:0];
      6'd25: next_byte = cur.signature[15:8];
      6'd26: next_byte = cur.signature[23:16];
      6'd27: next_byte = cur.signature[31:24];
      6'd28: next_byte = crc[7:0];
      6'd29: next_byte = crc[15:8];
      default: next_byte = 8'h00;
    endcase
  end

  // CRC16 update with the outgoing byte, bitwise lsb first as the radio sends
  always_comb
  begin
    logic fb;
    next_crc = crc;
    fb = 1'b0;
    for (int b = 0; b < 8; b++)
    begin
      fb = next_crc[0] ^ tx_data_o[b];
      next_crc = {1'b0, next_crc[15:1]};
      if (fb)
        next_crc = next_crc ^ 16'h8408;                      // reflected form of CRC_POLY
    end
  end

  // Sequencer
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state        <= ST_IDLE;
      idx          <= 6'd0;
      tx_valid_o   <= 1'b0;
      tx_last_o    <= 1'b0;
      evt_ready_o  <= 1'b0;
      frame_done_o <= 1'b0;
    end
    else
    begin
      frame_done_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          evt_ready_o <= 1'b1;
          if (take)
          begin
            state       <= ST_SEND;
            idx         <= 6'd0;
            evt_ready_o <= 1'b0;
          end
        end
        ST_SEND:
        begin
          if (!tx_valid_o)
          begin
            tx_valid_o <= 1'b1;
            tx_last_o  <= (idx == IDX_LAST);
          end
          else if (fire)
          begin
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
            if (idx == IDX_LAST)
              state <= ST_DONE;
            else
              idx <= idx + 6'd1;
          end
        end
        ST_DONE:
        begin
          frame_done_o <= 1'b1;
          evt_ready_o  <= 1'b1;
          state        <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Byte register loads when a new byte is presented
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      tx_data_o <= 8'h00;
    else if (state == ST_SEND && !tx_valid_o)
      tx_data_o <= next_byte;
  end

  // CRC covers the length byte through the last payload byte
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      crc <= CRC_INIT;
    else if (take)
      crc <= CRC_INIT;
    else if (fire && idx >= IDX_LEN && idx <= IDX_PAY_LAST)
      crc <= next_crc;
  end

  // Captured event and counters
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cur        <= '0;
      sent_evt_o <= '0;
      seq_num    <= SEQ_RESET;
      seq_cnt    <= CNT_RESET;
    end
    else if (take)
    begin
      cur        <= evt_i;
      sent_evt_o <= evt_i;
    end
    else if (state == ST_DONE)
    begin
      seq_num <= seq_num + 8'd1;
      seq_cnt <= seq_cnt + 32'd1;
    end
  end

  // Channel and frequency
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      chan_o     <= CHAN_DEFAULT;
      freq_mhz_o <= FREQ_BASE_MHZ;
    end
    else if (chan_wr_i && chan_i >= CHAN_MIN && chan_i <= CHAN_MAX && state == ST_IDLE)
    begin
      chan_o     <= chan_i;
      freq_mhz_o <= FREQ_BASE_MHZ
                  + 12'(FREQ_STEP_MHZ * 12'(chan_i - CHAN_MIN));
    end
  end

endmodule

// ==== testbench/framer_props_props.sv ====
// Checker for the framer byte stream and channel ports.
// Bound to every telegram_framer; sees only its ports.
`timescale 1ns/1ns
module framer_props
  import telegram_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        evt_valid_i,
  input wire logic        evt_ready_o,
  input wire logic        chan_wr_i,
  input wire logic [4:0]  chan_i,
  input wire logic [4:0]  chan_o,
  input wire logic [11:0] freq_mhz_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic        tx_last_o,
  input wire logic        frame_done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic ok;
  assign ok = chan_i >= CHAN_MIN && chan_i <= CHAN_MAX;
  chk_byte_holds: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("byte dropped");
  chk_gap_after: assert property (
    tx_valid_o && tx_ready_i |=> !tx_valid_o) else $error("no idle cycle");
  chk_take_answer: assert property (
    evt_valid_i && evt_ready_o |-> ##[1:2] tx_valid_o && tx_data_o == 8'h00)
    else $error("no preamble");
  chk_busy_refuse: assert property (
    tx_valid_o |-> !evt_ready_o) else $error("ready while busy");
  chk_done_follows: assert property (
    tx_valid_o && tx_ready_i && tx_last_o |-> ##[1:2] frame_done_o) else $error("no done");
  chk_done_pulse: assert property (
    frame_done_o |=> !frame_done_o) else $error("done too long");
  chk_chan_refuse: assert property (
    chan_wr_i && !ok |=> $stable(chan_o) && $stable(freq_mhz_o)) else $error("bad chan");
  chk_chan_take: assert property (
    chan_wr_i && ok && evt_ready_o && !evt_valid_i |=> chan_o == $past(chan_i)
    && freq_mhz_o == 12'd2405 + 12'd5 * ($past(chan_i) - 5'd11)) else $error("chan lost");
  cover property (frame_done_o);
  cover property (tx_valid_o && !tx_ready_i);
  cover property (chan_wr_i && ok && evt_ready_o);
endmodule
bind telegram_framer framer_props u_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .evt_valid_i(evt_valid_i), .evt_ready_o(evt_ready_o), .chan_wr_i(chan_wr_i),
  .chan_i(chan_i), .chan_o(chan_o), .freq_mhz_o(freq_mhz_o), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_last_o(tx_last_o),
  .frame_done_o(frame_done_o));

// ==== testbench/radio_sink.sv ====
// Radio receiver model: takes bytes on valid/ready and logs them.
// Slow mode holds ready low two cycles in three.
`timescale 1ns/1ns
module radio_sink (
  input  wire logic       clk_i,   // Framer clock
  input  wire logic       rst_i,   // Sync reset
  input  wire logic       slow_i,  // Stall mode
  input  wire logic [7:0] data_i,  // Frame byte
  input  wire logic       valid_i, // Byte valid
  input  wire logic       last_i,  // Final byte
  output logic            ready_o  // Byte taken
);
  logic [1:0] cyc;
  logic [8:0] got[$];
  always @(posedge clk_i)
  begin
    cyc <= (rst_i || cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
    ready_o <= !rst_i && (!slow_i || cyc == 2'h1);
    if (valid_i && ready_o)
      got.push_back({last_i, data_i});
  end
endmodule

// ==== testbench/pushbutton_telegram_framer_bench.sv ====
// Bench for the telegram framer against the radio receiver model.
// Inputs change 1 ns after each rising edge.
`timescale 1ns/1ns
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin miscompares++; \
  $display("BAD %0t %h %h", $time, g, x); end end
module pushbutton_telegram_framer_bench;
  import telegram_pkg::*;
  localparam logic [31:0] ID = 32'h0a0b0c0d; // Arbitrary identifier
  logic clk = 0, rst = 1, ev_v = 0, cw = 0, slow = 0, rdy, vld, last, done, erdy;
  logic [4:0] ci = 5'h0b, co;
  logic [11:0] fq;
  logic [7:0] td;
  logic [7:0] e[30];
  event_t ev = '0, se;
  int miscompares = 0, tests_run = 0, fn = 0;
  telegram_framer #(.DEVICE_ID(ID)) dut (.core_clk_i(clk), .rst_i(rst), .evt_valid_i(ev_v),
    .evt_i(ev), .evt_ready_o(erdy), .chan_wr_i(cw), .chan_i(ci), .chan_o(co),
    .freq_mhz_o(fq), .tx_data_o(td), .tx_valid_o(vld), .tx_ready_i(rdy),
    .tx_last_o(last), .frame_done_o(done), .sent_evt_o(se));
  radio_sink rx (.clk_i(clk), .rst_i(rst), .slow_i(slow), .data_i(td), .valid_i(vld),
    .last_i(last), .ready_o(rdy));
  initial forever #5 clk = ~clk;
  task automatic stop_test;
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic send(input logic rel, input logic [3:0] ct, input logic [7:0] cmd);
    logic [31:0] n, sig;
    logic [223:0] f;
    logic [15:0] c;
    logic [4:0] was;
    int k;
    n = fn;
    sig = 32'hc0de0000 + n;
    f = {sig, cmd, n, ID, 16'h308c, 32'hffffffff, n[7:0], 16'h0801, 8'h18, 8'ha7, 32'h0};
    c = 16'h0000;
    for (k = 0; k < 28; k++)
      e[k] = f[8*k +: 8];
    for (k = 40; k < 224; k++)
      c = (c >> 1) ^ ((c[0] ^ f[k]) ? 16'h8408 : 16'h0000);
    e[28] = c[7:0];
    e[29] = c[15:8];
    ev = {rel, ct, cmd, sig};
    rx.got.delete();
    was = co;
    ev_v = 1;
    for (k = 0; k < 50 && erdy !== 1'b1; k++)
      tick;
    if (k == 50)
    begin
      miscompares++;
      stop_test;
    end
    tick;
    ev_v = 0;
    `CHK(se, ev)
    cw = 1;
    ci = 5'd20;
    tick;
    cw = 0;
    `CHK(co, was)
    for (k = 0; k < 400 && done !== 1'b1; k++)
      tick;
    if (k == 400)
    begin
      miscompares++;
      stop_test;
    end
    `CHK(rx.got.size(), 30)
    for (k = 0; k < 30; k++)
      `CHK(rx.got[k], {k == 29, e[k]})
    fn++;
  endtask
  task automatic chans;
    logic [4:0] want;
    want = co;
    for (int i = 10; i <= 27; i++)
    begin
      cw = 1;
      ci = i[4:0];
      tick;
      cw = 0;
      tick;
      if (i >= 11 && i <= 26)
        want = i[4:0];
      `CHK(co, want)
      `CHK(fq, 12'd2405 + 12'd5 * (want - 5'd11))
    end
  endtask
  initial
  begin
    repeat (6) tick;
    rst = 0;
    repeat (3) tick;
    `CHK({co, fq, vld}, {5'd11, 12'd2405, 1'b0})
    send(1'b0, 4'b1000, 8'h22);
    slow = 1;
    send(1'b1, 4'b1000, 8'h23);
    chans;
    send(1'b0, 4'b0011, 8'h16);
    stop_test;
  end
endmodule
